// ---- include/lipmm_pkg.sv ----
/*
 * constants of the local interrupt pend/mask/map block: register offsets,
 * field positions, reset values and source numbering.
 * assumes a byte-addressed register port with 32-bit aligned words.
 */
package lipmm_pkg;
	// ****************************************************************
	// sizes
	// ****************************************************************
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int NUM_SRC = 7;
	localparam int MAP_W = 6;
	localparam int VEC_PINS = 6;
	localparam int YQ_W = 16;
	localparam int YQ_SEL_W = 4;
	// ****************************************************************
	// source numbering, one pending/enable bit each
	// ****************************************************************
	localparam int SRC_WD = 0;
	localparam int SRC_CMP = 1;
	localparam int SRC_TIMER = 2;
	localparam int SRC_PERF = 3;
	localparam int SRC_SW0 = 4;
	localparam int SRC_SW1 = 5;
	localparam int SRC_DBG = 6;
	// ****************************************************************
	// register offsets
	// ****************************************************************
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_PEND = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_MASK = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CLR = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_SET = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_ROUTE_WD = 8'h40;
	localparam logic [ADDR_W-1:0] OFS_ROUTE_CMP = 8'h44;
	localparam logic [ADDR_W-1:0] OFS_ROUTE_TIMER = 8'h48;
	localparam logic [ADDR_W-1:0] OFS_ROUTE_DBG = 8'h4C;
	localparam logic [ADDR_W-1:0] OFS_ROUTE_PERF = 8'h50;
	localparam logic [ADDR_W-1:0] OFS_ROUTE_SW0 = 8'h54;
	localparam logic [ADDR_W-1:0] OFS_ROUTE_SW1 = 8'h58;
	localparam logic [ADDR_W-1:0] OFS_DBG_SEND = 8'h60;
	localparam logic [ADDR_W-1:0] OFS_DBG_PART = 8'h64;
	// ****************************************************************
	// fields and reset values
	// ****************************************************************
	localparam int RT_CORE_BIT = 31;
	localparam int RT_NMI_BIT = 30;
	localparam int RT_YQ_BIT = 29;
	localparam logic [DATA_W-1:0] ROUTE_WMASK = 32'hE000_003F;
	localparam logic [DATA_W-1:0] ROUTE_RESET = 32'h0000_0000;
	localparam int CTRL_EXT_BIT = 0;
	localparam int DBG_SEND_BIT = 0;
	localparam int DBG_PART_BIT = 0;
	localparam logic [NUM_SRC-1:0] MASK_RESET = 7'h00;
	localparam logic [MAP_W-1:0] VEC_MAX = 6'h05;
endpackage

// ---- src/lipmm_sync.sv ----
/*
 * three-stage synchroniser for a group of source levels.
 * assumes the sources are levels from outside the clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module lipmm_sync #(
	parameter int W = 7
) (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// levels
	input wire logic [W-1:0] raw,
	output logic [W-1:0] level
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	// refused at elaboration, a zero-width group has nothing to carry
	if (W < 1)
	begin : g_bad_width
		$error("sync width must be positive");
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end
		else
		begin
			s1 <= raw;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// a bit only moves once the last two stages agree
	for (genvar i = 0; i < W; i++)
	begin : g_agree
		always_ff @(posedge clock)
		begin
			if (!nrst)
				level[i] <= 1'b0;
			else if (s2[i] == s3[i])
				level[i] <= s3[i];
		end
	end
endmodule
`default_nettype wire

// ---- src/lipmm_route.sv ----
/*
 * route decoder for one local source: turns an active source and its
 * route word into core input, nonmaskable and yield qualifier requests.
 * assumes the caller has already gated the source with its enable.
 */
`timescale 1ns/1ps
`default_nettype none
module lipmm_route (
	// source and setup
	input wire logic active,
	input wire logic extMode,
	input wire logic [lipmm_pkg::DATA_W-1:0] route,
	// requests
	output logic [lipmm_pkg::VEC_PINS-1:0] vecPins,
	output logic [lipmm_pkg::MAP_W-1:0] level,
	output logic nmi,
	output logic [lipmm_pkg::YQ_W-1:0] yq
);
	import lipmm_pkg::*;

	logic toCore;
	logic toNmi;
	logic toYq;
	logic single;
	logic [MAP_W-1:0] mapField;

	assign toCore = route[RT_CORE_BIT];
	assign toNmi = route[RT_NMI_BIT];
	assign toYq = route[RT_YQ_BIT];
	assign mapField = route[MAP_W-1:0];
	// more than one type bit set routes nowhere
	assign single = (32'(toCore) + 32'(toNmi) + 32'(toYq)) == 32'd1;

	always_comb
	begin
		vecPins = '0;
		level = '0;
		nmi = 1'b0;
		yq = '0;
		if (active && single)
		begin
			if (toCore && extMode)
				level = mapField;
			else if (toCore && mapField <= VEC_MAX)
				vecPins[mapField[2:0]] = 1'b1;
			nmi = toNmi;
			if (toYq)
				yq[mapField[YQ_SEL_W-1:0]] = 1'b1;
		end
	end
endmodule
`default_nettype wire

// ---- src/lipmm_top.sv ----
/*
 * local interrupt pend/mask/map block for one thread context, with the
 * group debug interrupt send path.
 * assumes source levels arrive asynchronously, a single-cycle strobe
 * register port, and a core that samples the outputs every clock.
 */
// The strobed register port was left to the implementer.
// Operation
// - timer source sets pending bit 2
// - perf counter sets pending bit 3, mask bit 3
// - soft interrupt 0 uses bit 4
// - soft interrupt 1 uses bit 5
// - debug channel event uses bit 6
// - enable register at 0x08 gates pending bits
// - write-only set register at 0x10 enables
// - write-only clear register at 0x0C disables
// - enable register reads state, ignores writes
// - pending register at 0x04 is read-only status
// - timer routed by register 0x48
// - perf counter routed by register 0x50
// - soft interrupt 0 routed by register 0x54
// - soft interrupt 1 routed by register 0x58
// - debug channel routed by register 0x4C
// - vectored mode: map 0 to 5 picks input
// - external mode drives encoded map level
// - control bit selects external mode, resets 0
// - soft interrupts pass only in external mode
// - send bit raises group debug output
// - context debug is group and partition
// - only one route type bit may be set
// - route bit 31 and bits 5:0 map
`timescale 1ns/1ps
`default_nettype none
module lipmm_top (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// local interrupt sources, asynchronous levels
	input wire logic [lipmm_pkg::NUM_SRC-1:0] srcRaw,
	// register port
	input wire logic [lipmm_pkg::ADDR_W-1:0] regAddr,
	input wire logic [lipmm_pkg::DATA_W-1:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [lipmm_pkg::DATA_W-1:0] regRdata,
	// core interrupt inputs
	output logic [lipmm_pkg::MAP_W-1:0] coreIrq,
	output logic nmiIrq,
	output logic [lipmm_pkg::YQ_W-1:0] yieldQualifier,
	output logic extControllerMode,
	// debug interrupts
	output logic groupDebugIrq,
	output logic contextDebugIrq
);
	import lipmm_pkg::*;

	// ****************************************************************
	// address decoding
	// ****************************************************************
	function automatic logic [NUM_SRC-1:0] routeSel(
		input logic [ADDR_W-1:0] a
	);
		routeSel = '0;
		unique case (a)
			OFS_ROUTE_WD: routeSel[SRC_WD] = 1'b1;
			OFS_ROUTE_CMP: routeSel[SRC_CMP] = 1'b1;
			OFS_ROUTE_TIMER: routeSel[SRC_TIMER] = 1'b1;
			OFS_ROUTE_DBG: routeSel[SRC_DBG] = 1'b1;
			OFS_ROUTE_PERF: routeSel[SRC_PERF] = 1'b1;
			OFS_ROUTE_SW0: routeSel[SRC_SW0] = 1'b1;
			OFS_ROUTE_SW1: routeSel[SRC_SW1] = 1'b1;
			default: routeSel = '0;
		endcase
	endfunction

	function automatic logic hit(
		input logic strobe,
		input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] ofs
	);
		hit = strobe && (a == ofs);
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************
	logic [NUM_SRC-1:0] srcLevel;
	logic [NUM_SRC-1:0] pending;
	logic [NUM_SRC-1:0] enable;
	logic [DATA_W-1:0] route [NUM_SRC];
	logic extMode;
	logic debugSend;
	logic debugPart;
	logic [NUM_SRC-1:0] wrRoute;
	logic [NUM_SRC-1:0] rdRoute;
	logic [NUM_SRC-1:0] active;
	logic [VEC_PINS-1:0] vecPins [NUM_SRC];
	logic [MAP_W-1:0] level [NUM_SRC];
	logic [NUM_SRC-1:0] nmiReq;
	logic [YQ_W-1:0] yqReq [NUM_SRC];
	logic [MAP_W-1:0] next_coreIrq;
	logic next_nmiIrq;
	logic [YQ_W-1:0] next_yieldQualifier;
	logic [DATA_W-1:0] next_regRdata;

	assign wrRoute = regWrite ? routeSel(regAddr) : '0;
	assign rdRoute = routeSel(regAddr);

	// ****************************************************************
	// source capture
	// ****************************************************************
	lipmm_sync #(
		.W(NUM_SRC)
	) u_sync (
		.clock(clock),
		.nrst(nrst),
		.raw(srcRaw),
		.level(srcLevel)
	);

	// pending tracks each source level whatever the enable says
	always_ff @(posedge clock)
	begin
		if (!nrst)
			pending <= '0;
		else
			pending <= srcLevel;
	end

	// ****************************************************************
	// enable set and clear
	// ****************************************************************
	// set and clear never share a cycle, so no ordering hazard
	always_ff @(posedge clock)
	begin
		if (!nrst)
			enable <= MASK_RESET;
		else if (hit(regWrite, regAddr, OFS_SET))
			enable <= enable | regWdata[NUM_SRC-1:0];
		else if (hit(regWrite, regAddr, OFS_CLR))
			enable <= enable & ~regWdata[NUM_SRC-1:0];
	end

	// ****************************************************************
	// control, route and debug registers
	// ****************************************************************
	always_ff @(posedge clock)
	begin
		if (!nrst)
			extMode <= 1'b0;
		else if (hit(regWrite, regAddr, OFS_CTRL))
			extMode <= regWdata[CTRL_EXT_BIT];
	end

	for (genvar i = 0; i < NUM_SRC; i++)
	begin : g_route
		always_ff @(posedge clock)
		begin
			if (!nrst)
				route[i] <= ROUTE_RESET;
			else if (wrRoute[i])
				route[i] <= regWdata & ROUTE_WMASK;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
			debugSend <= 1'b0;
		else if (hit(regWrite, regAddr, OFS_DBG_SEND))
			debugSend <= regWdata[DBG_SEND_BIT];
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
			debugPart <= 1'b0;
		else if (hit(regWrite, regAddr, OFS_DBG_PART))
			debugPart <= regWdata[DBG_PART_BIT];
	end

	// ****************************************************************
	// masking and routing
	// ****************************************************************
	// soft interrupts are the core's own business in vectored mode
	always_comb
	begin
		active = pending & enable;
		if (!extMode)
		begin
			active[SRC_SW0] = 1'b0;
			active[SRC_SW1] = 1'b0;
		end
	end

	for (genvar i = 0; i < NUM_SRC; i++)
	begin : g_map
		lipmm_route u_route (
			.active(active[i]),
			.extMode(extMode),
			.route(route[i]),
			.vecPins(vecPins[i]),
			.level(level[i]),
			.nmi(nmiReq[i]),
			.yq(yqReq[i])
		);
	end

	// external mode presents the highest requested level only
	always_comb
	begin
		next_coreIrq = '0;
		next_yieldQualifier = '0;
		next_nmiIrq = |nmiReq;
		for (int i = 0; i < NUM_SRC; i++)
		begin
			next_yieldQualifier = next_yieldQualifier | yqReq[i];
			if (extMode)
			begin
				if (level[i] > next_coreIrq)
					next_coreIrq = level[i];
			end
			else
				next_coreIrq = next_coreIrq | vecPins[i];
		end
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			coreIrq <= '0;
			nmiIrq <= 1'b0;
			yieldQualifier <= '0;
			extControllerMode <= 1'b0;
		end
		else
		begin
			coreIrq <= next_coreIrq;
			nmiIrq <= next_nmiIrq;
			yieldQualifier <= next_yieldQualifier;
			extControllerMode <= extMode;
		end
	end

	// ****************************************************************
	// debug interrupt outputs
	// ****************************************************************
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			groupDebugIrq <= 1'b0;
			contextDebugIrq <= 1'b0;
		end
		else
		begin
			groupDebugIrq <= debugSend;
			contextDebugIrq <= debugSend && debugPart;
		end
	end

	// ****************************************************************
	// register read
	// ****************************************************************
	// write-only and unmapped words read zero, never stale data
	always_comb
	begin
		next_regRdata = '0;
		if (regRead)
		begin
			if (regAddr == OFS_PEND)
				next_regRdata[NUM_SRC-1:0] = pending;
			else if (regAddr == OFS_MASK)
				next_regRdata[NUM_SRC-1:0] = enable;
			else if (regAddr == OFS_CTRL)
				next_regRdata[CTRL_EXT_BIT] = extMode;
			else if (regAddr == OFS_DBG_SEND)
				next_regRdata[DBG_SEND_BIT] = debugSend;
			else if (regAddr == OFS_DBG_PART)
				next_regRdata[DBG_PART_BIT] = debugPart;
			else
			begin
				for (int i = 0; i < NUM_SRC; i++)
					if (rdRoute[i])
						next_regRdata = route[i];
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
			regRdata <= '0;
		else
			regRdata <= next_regRdata;
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cbCheck @(posedge clock);
	endclocking
	default disable iff (!nrst);

	a_cpu_timer_pending: assert property (
		srcLevel[SRC_TIMER] |=> pending[SRC_TIMER])
		else $error("timer pending bit not set");

	a_perf_pend: assert property (
		pending[SRC_PERF] == $past(srcLevel[SRC_PERF]))
		else $error("perf pending bit wrong");

	a_soft_pend: assert property (
		pending[SRC_SW1:SRC_SW0] == $past(srcLevel[SRC_SW1:SRC_SW0]))
		else $error("soft pending bits wrong");

	a_dbgchan_pend: assert property (
		$rose(srcLevel[SRC_DBG]) |=> $rose(pending[SRC_DBG]))
		else $error("debug channel pending not set");

	a_enable_set: assert property (
		regWrite && regAddr == OFS_SET && regWdata[SRC_TIMER]
		|=> enable[SRC_TIMER])
		else $error("set write did not enable");

	a_enable_clear: assert property (
		regWrite && regAddr == OFS_CLR && regWdata[SRC_DBG]
		|=> !enable[SRC_DBG])
		else $error("clear write did not disable");

	a_enable_ro: assert property (
		regWrite && regAddr == OFS_MASK |=> $stable(enable))
		else $error("enable register took a write");

	a_pend_read: assert property (
		regRead && regAddr == OFS_PEND
		|=> regRdata == {{(DATA_W-NUM_SRC){1'b0}}, $past(pending)})
		else $error("pending read value wrong");

	a_nmi_cause: assert property (
		nmiIrq |-> $past(|(pending & enable)))
		else $error("nmi without enabled pending source");

	a_soft_gate: assert property (
		!extMode && !(|(pending & enable & 7'h4F)) |=> coreIrq == '0)
		else $error("soft interrupt passed in vectored mode");

	a_debug_send: assert property (
		regWrite && regAddr == OFS_DBG_SEND && regWdata[DBG_SEND_BIT]
		|=> ##1 groupDebugIrq)
		else $error("group debug not raised");

	a_ctx_debug: assert property (
		contextDebugIrq |-> groupDebugIrq && $past(debugPart))
		else $error("context debug without group and partition");

	c_timer_vector: cover property (!extMode && pending[SRC_TIMER]
		&& enable[SRC_TIMER] ##1 coreIrq != '0);
	c_ext_level: cover property (extMode && coreIrq > VEC_MAX);
	c_nmi: cover property (nmiIrq);
	c_ctx_debug: cover property (contextDebugIrq);
endmodule
`default_nettype wire

// ---- sim/lipmm_core_model.sv ----
/*
 * core side model: takes the interrupt and debug inputs on every rising edge.
 * assumes the block drives registered levels from the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module lipmm_core_model (
	// clock
	input wire logic clock,
	// interrupt inputs from the block
	input wire logic [lipmm_pkg::MAP_W-1:0] coreIrq,
	input wire logic nmiIrq,
	input wire logic [lipmm_pkg::YQ_W-1:0] yieldQualifier,
	input wire logic extControllerMode,
	input wire logic groupDebugIrq,
	input wire logic contextDebugIrq,
	// what the core last took
	output logic [25:0] seen
);
	import lipmm_pkg::*;
	// ********
	// sampling
	// ********
	// levels only, so a late sample loses nothing
	always_ff @(posedge clock)
	begin
		seen <= {groupDebugIrq, contextDebugIrq, extControllerMode, nmiIrq,
			yieldQualifier, coreIrq};
	end
endmodule
`default_nettype wire

// ---- sim/lipmm_top_bench.sv ----
/*
 * self-checking bench of the local interrupt block, random and corner.
 * assumes the package and the core model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module lipmm_top_bench;
	import lipmm_pkg::*;
	// ********
	// state
	// ********
	localparam logic [ADDR_W-1:0] ROFS [NUM_SRC] = '{OFS_ROUTE_WD,
		OFS_ROUTE_CMP, OFS_ROUTE_TIMER, OFS_ROUTE_PERF, OFS_ROUTE_SW0,
		OFS_ROUTE_SW1, OFS_ROUTE_DBG};
	logic clock = 1'h0;
	logic nrst = 1'h0;
	logic [NUM_SRC-1:0] srcRaw = '0;
	logic [ADDR_W-1:0] regAddr = '0;
	logic [DATA_W-1:0] regWdata = '0;
	logic regWrite = 1'h0;
	logic regRead = 1'h0;
	logic [DATA_W-1:0] regRdata;
	logic [MAP_W-1:0] coreIrq;
	logic nmiIrq;
	logic [YQ_W-1:0] yieldQualifier;
	logic extControllerMode;
	logic groupDebugIrq;
	logic contextDebugIrq;
	logic [25:0] seen;
	logic [DATA_W-1:0] rt [NUM_SRC] = '{default: '0};
	logic [NUM_SRC-1:0] msk = '0;
	logic ext = 1'h0;
	logic snd = 1'h0;
	logic prt = 1'h0;
	logic [31:0] seed = 32'hCBAA;
	logic [31:0] v;
	logic [31:0] w;
	logic [31:0] r;
	int nFail = 0;
	int nChecks = 0;

	always #50 clock = ~clock;

	lipmm_top lipmm_top_inst (.clock(clock), .nrst(nrst), .srcRaw(srcRaw),
		.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
		.regRead(regRead), .regRdata(regRdata), .coreIrq(coreIrq),
		.nmiIrq(nmiIrq), .yieldQualifier(yieldQualifier),
		.extControllerMode(extControllerMode),
		.groupDebugIrq(groupDebugIrq), .contextDebugIrq(contextDebugIrq));
	lipmm_core_model lipmm_core_model_inst (.clock(clock),
		.coreIrq(coreIrq), .nmiIrq(nmiIrq), .yieldQualifier(yieldQualifier),
		.extControllerMode(extControllerMode),
		.groupDebugIrq(groupDebugIrq), .contextDebugIrq(contextDebugIrq),
		.seen(seen));
	// ********
	// expectations
	// ********
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [DATA_W-1:0] expReg(input logic [ADDR_W-1:0] a);
		logic [DATA_W-1:0] e;
		e = '0;
		for (int s = 0; s < NUM_SRC; s++)
			if (a == ROFS[s])
				e = rt[s];
		case (a)
			OFS_CTRL: e = {31'h0, ext};
			OFS_PEND: e = {25'h0, srcRaw};
			OFS_MASK: e = {25'h0, msk};
			OFS_DBG_SEND: e = {31'h0, snd};
			OFS_DBG_PART: e = {31'h0, prt};
			default: ;
		endcase
		return e;
	endfunction

	function automatic logic [25:0] expOut();
		logic [MAP_W-1:0] lvl;
		logic [MAP_W-1:0] vec;
		logic nmi;
		logic [YQ_W-1:0] yq;
		logic [DATA_W-1:0] q;
		lvl = '0;
		vec = '0;
		nmi = 1'h0;
		yq = '0;
		for (int s = 0; s < NUM_SRC; s++)
		begin
			q = rt[s];
			// soft sources stay inside the core in vectored mode
			if (srcRaw[s] && msk[s] && (ext || (s != SRC_SW0 && s != SRC_SW1)))
			begin
				if (q[31:29] == 3'h4 && ext && q[5:0] > lvl)
					lvl = q[5:0];
				if (q[31:29] == 3'h4 && !ext && q[5:0] <= VEC_MAX)
					vec[q[5:0]] = 1'h1;
				if (q[31:29] == 3'h2)
					nmi = 1'h1;
				if (q[31:29] == 3'h1)
					yq[q[3:0]] = 1'h1;
			end
		end
		return {snd, snd & prt, ext, nmi, yq, ext ? lvl : vec};
	endfunction
	// ********
	// compare and bus tasks
	// ********
	task automatic fail(input string m);
		nFail++;
		$display("ERROR %0t %s", $time, m);
	endtask

	task automatic chkReg(input logic [DATA_W-1:0] got,
		input logic [DATA_W-1:0] exp);
		nChecks++;
		if (got !== exp)
			fail($sformatf("read data %h expected %h", got, exp));
	endtask

	task automatic chkOut();
		// long enough for the synchroniser and the output flops
		repeat (8) @(posedge clock);
		@(negedge clock);
		nChecks++;
		if (seen !== expOut())
			fail($sformatf("outputs %h expected %h", seen, expOut()));
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clock);
		regWrite <= 1'h1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clock);
		regWrite <= 1'h0;
		case (a)
			OFS_CTRL: ext = d[0];
			OFS_SET: msk = msk | d[6:0];
			OFS_CLR: msk = msk & ~d[6:0];
			OFS_DBG_SEND: snd = d[0];
			OFS_DBG_PART: prt = d[0];
			default: ;
		endcase
		for (int s = 0; s < NUM_SRC; s++)
			if (a == ROFS[s])
				rt[s] = d & ROUTE_WMASK;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge clock);
		regRead <= 1'h1;
		regAddr <= a;
		@(posedge clock);
		regRead <= 1'h0;
		@(negedge clock);
		chkReg(regRdata, expReg(a));
		@(negedge clock);
		chkReg(regRdata, '0);
	endtask

	task automatic setSrc(input logic [NUM_SRC-1:0] d);
		@(posedge clock);
		srcRaw <= d;
	endtask

	task automatic endOfTest();
		$display("checks %0d mismatches %0d", nChecks, nFail);
		if (nFail == 0 && nChecks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ********
	// sequence
	// ********
	initial
	begin
		repeat (16) @(posedge clock);
		nrst <= 1'h1;
		chkOut();
		for (int a = 0; a < 128; a += 4)
			rd(8'(a));
		wr(OFS_MASK, 32'hFFFF_FFFF);
		wr(OFS_PEND, 32'hFFFF_FFFF);
		rd(OFS_MASK);
		rd(OFS_PEND);
		$display("test register map done");
		for (int m = 0; m < 2; m++)
		begin
			wr(OFS_CTRL, 32'(m));
			for (int s = 0; s < NUM_SRC; s++)
			begin
				wr(ROFS[s], 32'h8000_0000 | 32'(m ? 32 + s : s % 6));
				wr(OFS_SET, 32'h1 << s);
				setSrc(7'h1 << s);
				chkOut();
				rd(OFS_PEND);
				rd(OFS_MASK);
				wr(OFS_CLR, 32'h1 << s);
				chkOut();
			end
		end
		$display("test source routing done");
		wr(OFS_CTRL, 32'h0);
		wr(OFS_SET, 32'h7F);
		setSrc(7'h04);
		wr(OFS_ROUTE_TIMER, 32'h8000_0006);
		chkOut();
		wr(OFS_ROUTE_TIMER, 32'hC000_0001);
		chkOut();
		wr(OFS_ROUTE_TIMER, 32'h4000_0000);
		chkOut();
		wr(OFS_ROUTE_TIMER, 32'h2000_000F);
		chkOut();
		wr(OFS_DBG_SEND, 32'h1);
		chkOut();
		wr(OFS_DBG_PART, 32'h1);
		chkOut();
		wr(OFS_DBG_SEND, 32'h0);
		chkOut();
		$display("test refused routes and debug done");
		repeat (60)
		begin
			v = rnd();
			w = rnd();
			case (v[2:0])
				3'h0: wr(OFS_SET, w);
				3'h1: wr(OFS_CLR, w);
				3'h2:
				begin
					// one type bit at most, vectored map kept legal
					r = w & 32'h1FFF_FFC0;
					if (v[7:6] != 2'h0)
						r[32 - v[7:6]] = 1'h1;
					r[5:0] = 6'(v[11:8] % 6);
					wr(ROFS[v[5:3] % 7], r);
				end
				3'h3: wr(OFS_CTRL, {31'h0, w[0]});
				3'h4: setSrc(w[6:0]);
				3'h5: wr(OFS_DBG_SEND, {31'h0, w[0]});
				3'h6: wr(OFS_DBG_PART, {31'h0, w[0]});
				default: rd(w[7:0] & 8'h7C);
			endcase
			chkOut();
			rd(OFS_PEND);
			rd(OFS_MASK);
		end
		$display("test random traffic done");
		// reset in mid-run must drop every register and output
		wr(OFS_CTRL, 32'h1);
		wr(OFS_SET, 32'h7F);
		wr(OFS_ROUTE_TIMER, 32'h8000_0021);
		wr(OFS_DBG_SEND, 32'h1);
		wr(OFS_DBG_PART, 32'h1);
		@(posedge clock);
		nrst <= 1'h0;
		repeat (4) @(posedge clock);
		nrst <= 1'h1;
		ext = 1'h0;
		snd = 1'h0;
		prt = 1'h0;
		msk = '0;
		rt = '{default: '0};
		chkOut();
		rd(OFS_CTRL);
		rd(OFS_MASK);
		rd(OFS_ROUTE_TIMER);
		rd(OFS_PEND);
		$display("test reset in mid-run done");
		endOfTest();
	end

	initial
	begin
		repeat (20000) @(posedge clock);
		fail("watchdog expired");
		endOfTest();
	end
endmodule
`default_nettype wire
